// file: rtl/tdcrg_pkg.sv
// Shared constants for the reset and hit-gating front end and its controller.
// Assumes a single 100 MHz clock shared by both ends.
package tdcrg_pkg;

    // ----------------------------------------------------------------
    // Clock and timing figures
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWRUP_MIN_NS = 200;
    localparam int PULSE_MIN_NS = 10;
    localparam int MASTER_RISE_NS = 27;
    localparam int PARTIAL_RISE_NS = 60;
    localparam int FALL_HOLD_NS = 13;
    // Least times round up to whole cycles
    localparam int PWRUP_CYC = (PWRUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MASTER_RISE_CYC = (MASTER_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PARTIAL_RISE_CYC = (PARTIAL_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FALL_HOLD_CYC = (FALL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // Cycles from a pin change to the device's agreed sample of it
    localparam int SYNC_LAT_CYC = 4;

    // ----------------------------------------------------------------
    // Host controller commands
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TDCRG_CMD_PWRUP,
        TDCRG_CMD_MASTER,
        TDCRG_CMD_PARTIAL,
        TDCRG_CMD_WRITE,
        TDCRG_CMD_READ
    } tdcrg_cmd_t;

endpackage : tdcrg_pkg

// file: rtl/tdcrg_if.sv
// Pins between the host controller and the hit-gating front end.
// Assumes both ends run on the same ref_clk.
`timescale 1ns/1ns
`default_nettype none
interface tdcrg_if;
    logic pwrup_reset;
    logic master_reset;
    logic partial_reset;
    logic start_mask_in;
    logic stop_mask_a;
    logic stop_mask_b;
    logic stop_mask_c;
    logic stop_mask_d;
    logic chip_select_n;
    logic write_strobe_n;
    logic read_strobe_n;

    modport host (
        output pwrup_reset, master_reset, partial_reset, start_mask_in,
        output stop_mask_a, stop_mask_b, stop_mask_c, stop_mask_d,
        output chip_select_n, write_strobe_n, read_strobe_n
    );
    modport dev (
        input pwrup_reset, master_reset, partial_reset, start_mask_in,
        input stop_mask_a, stop_mask_b, stop_mask_c, stop_mask_d,
        input chip_select_n, write_strobe_n, read_strobe_n
    );
endinterface : tdcrg_if
`default_nettype wire

// file: rtl/tdcrg_host.sv
// Host controller: drives reset pulses, disable pins and port strobes.
// Assumes one command at a time; cmd_ready shows when the next may come.
`timescale 1ns/1ns
`default_nettype none
module tdcrg_host (
    input wire logic ref_clk,
    input wire logic rst,
    tdcrg_if.host link,
    input wire logic cmd_valid,
    input wire tdcrg_pkg::tdcrg_cmd_t cmd,
    input wire logic [4:0] mask_set,
    output logic cmd_ready
);

    typedef enum logic [1:0] {TDCRG_H_IDLE, TDCRG_H_PULSE, TDCRG_H_GAP} tdcrg_hstate_t;

    tdcrg_hstate_t state_r;
    tdcrg_pkg::tdcrg_cmd_t cmd_r;
    logic [tdcrg_pkg::CNT_W-1:0] cnt_r;
    logic [4:0] mask_r;

    // ----------------------------------------------------------------
    // Pulse sequencer
    // ----------------------------------------------------------------
    // Reset and strobe widths held long enough for the device to see them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= TDCRG_H_IDLE;
            cmd_r <= tdcrg_pkg::TDCRG_CMD_READ;
            cnt_r <= '0;
        end else begin
            case (state_r)
                TDCRG_H_IDLE: begin
                    if (cmd_valid) begin
                        cmd_r <= cmd;
                        state_r <= TDCRG_H_PULSE;
                        if (cmd == tdcrg_pkg::TDCRG_CMD_PWRUP) begin
                            cnt_r <= tdcrg_pkg::CNT_W'(tdcrg_pkg::PWRUP_CYC + 3);
                        end else begin
                            // Margin for the far end's three-stage sampler
                            cnt_r <= tdcrg_pkg::CNT_W'(tdcrg_pkg::PULSE_CYC + 3);
                        end
                    end
                end
                TDCRG_H_PULSE: begin
                    if (cnt_r == 1) begin
                        state_r <= TDCRG_H_GAP;
                        cnt_r <= tdcrg_pkg::CNT_W'(3);
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                TDCRG_H_GAP: begin
                    if (cnt_r == 1) begin
                        state_r <= TDCRG_H_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: state_r <= TDCRG_H_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers, all registered
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            link.pwrup_reset <= 1'b0;
            link.master_reset <= 1'b0;
            link.partial_reset <= 1'b0;
            link.chip_select_n <= 1'b1;
            link.write_strobe_n <= 1'b1;
            link.read_strobe_n <= 1'b1;
            cmd_ready <= 1'b0;
        end else begin
            link.pwrup_reset <= (state_r == TDCRG_H_PULSE) && (cmd_r == tdcrg_pkg::TDCRG_CMD_PWRUP);
            link.master_reset <= (state_r == TDCRG_H_PULSE) && (cmd_r == tdcrg_pkg::TDCRG_CMD_MASTER);
            link.partial_reset <= (state_r == TDCRG_H_PULSE)
                && (cmd_r == tdcrg_pkg::TDCRG_CMD_PARTIAL);
            // Select falls with the strobe and stays low through the gap
            link.chip_select_n <= !((state_r != TDCRG_H_IDLE)
                && (cmd_r == tdcrg_pkg::TDCRG_CMD_WRITE || cmd_r == tdcrg_pkg::TDCRG_CMD_READ));
            link.write_strobe_n <= !((state_r == TDCRG_H_PULSE)
                && (cmd_r == tdcrg_pkg::TDCRG_CMD_WRITE));
            link.read_strobe_n <= !((state_r == TDCRG_H_PULSE)
                && (cmd_r == tdcrg_pkg::TDCRG_CMD_READ));
            cmd_ready <= (state_r == TDCRG_H_IDLE) && !cmd_valid;
        end
    end

    // Disable levels, active high
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_r <= '0;
        end else begin
            mask_r <= mask_set;
        end
    end
    assign link.start_mask_in = mask_r[0];
    assign link.stop_mask_a = mask_r[1];
    assign link.stop_mask_b = mask_r[2];
    assign link.stop_mask_c = mask_r[3];
    assign link.stop_mask_d = mask_r[4];

endmodule : tdcrg_host
`default_nettype wire

// file: rtl/tdcrg_dev.sv
// Device end: reset dead windows, disable masking and port strobe decode.
// Assumes pins arrive asynchronously; hit inputs are already edge pulses.
`timescale 1ns/1ns
`default_nettype none
module tdcrg_dev #(
    parameter int LOSS_CYC = 2,
    parameter int RES_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    tdcrg_if.dev link,
    input wire logic ttl_sel,
    input wire logic diff_begin_in,
    input wire logic diff_end_in_a,
    input wire logic diff_end_in_b,
    input wire logic ttl_begin_in,
    input wire logic [7:0] ttl_end_in,
    input wire logic res_adjust_en,
    input wire logic [RES_W-1:0] res_target,
    input wire logic [RES_W-1:0] res_measured,
    output logic begin_hit,
    output logic [1:0] diff_end_hit,
    output logic [7:0] ttl_end_hit,
    output logic hits_open,
    output logic wr_access,
    output logic rd_access,
    output logic core_init,
    output logic [RES_W-1:0] core_trim
);

    localparam int NPIN = 10;
    // Three-stage sampler per pin; stages 2 and 3 must agree
    logic [NPIN-1:0] s1_r, s2_r, s3_r, pin_r;
    logic pin_partial, pin_master, pin_pwrup;
    logic [tdcrg_pkg::CNT_W-1:0] dead_r;
    // Hits wait out the pin sampler latency plus the pre-rise loss span
    localparam int DLY = LOSS_CYC + tdcrg_pkg::SYNC_LAT_CYC;
    logic hit_ok;
    logic [7:0] ttl_mask;

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    // Only stages 2 and 3 are compared; stage 1 may be metastable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0; // Strobes idle, so no false access edge
        end else begin
            s1_r <= {!link.read_strobe_n, !link.write_strobe_n, !link.chip_select_n,
                link.stop_mask_d, link.stop_mask_c, link.stop_mask_b, link.stop_mask_a,
                link.start_mask_in, link.partial_reset, link.master_reset};
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < NPIN; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    pin_r[i] <= s2_r[i];
                end
            end
        end
    end
    assign pin_master = pin_r[0];
    assign pin_partial = pin_r[1];

    // Power-up pin kept separate: it re-inits the core
    logic [2:0] pu_r;
    logic pwrup_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pu_r <= '0;
            pwrup_r <= 1'b0;
        end else begin
            pu_r <= {pu_r[1:0], link.pwrup_reset};
            // Same agreement rule as the other pins, for rise and fall
            if (pu_r[1] == pu_r[2]) begin
                pwrup_r <= pu_r[1];
            end
        end
    end
    assign pin_pwrup = pwrup_r;

    // ----------------------------------------------------------------
    // Dead window after reset edges
    // ----------------------------------------------------------------
    // Pulses shorter than the minimum width are not policed; the host owns that
    logic master_d_r, partial_d_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            master_d_r <= 1'b0;
            partial_d_r <= 1'b0;
            dead_r <= '0;
        end else begin
            master_d_r <= pin_master;
            partial_d_r <= pin_partial;
            if (pin_pwrup || pin_master || pin_partial) begin
                // Held at least until fall plus the fall hold
                dead_r <= tdcrg_pkg::CNT_W'(tdcrg_pkg::FALL_HOLD_CYC);
                if (pin_partial && !partial_d_r) begin
                    dead_r <= tdcrg_pkg::CNT_W'(tdcrg_pkg::PARTIAL_RISE_CYC);
                end else if (pin_master && !master_d_r) begin
                    dead_r <= tdcrg_pkg::CNT_W'(tdcrg_pkg::MASTER_RISE_CYC);
                end else if (dead_r > tdcrg_pkg::CNT_W'(tdcrg_pkg::FALL_HOLD_CYC)) begin
                    dead_r <= dead_r - 1'b1;
                end
            end else if (dead_r != 0) begin
                dead_r <= dead_r - 1'b1;
            end
        end
    end
    // Gate open only with no reset pin high and the dead count spent
    assign hit_ok = (dead_r == 0) && !pin_master && !pin_partial && !pin_pwrup;

    // ----------------------------------------------------------------
    // Hit gating
    // ----------------------------------------------------------------
    // Each single-ended stop pair follows one stop mask
    assign ttl_mask = {{2{pin_r[6]}}, {2{pin_r[5]}}, {2{pin_r[4]}}, {2{pin_r[3]}}};

    // Hits delayed DLY cycles: a rise still in the sampler, or a partial
    // rise up to LOSS_CYC cycles later, closes the gate in time to drop them
    logic [DLY-1:0] b_dly_r;
    logic [1:0] d_dly_r [DLY];
    logic [7:0] t_dly_r [DLY];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            b_dly_r <= '0;
            for (int i = 0; i < DLY; i++) begin
                d_dly_r[i] <= '0;
                t_dly_r[i] <= '0;
            end
        end else begin
            b_dly_r[0] <= hit_ok && !pin_r[2]
                && (ttl_sel ? ttl_begin_in : diff_begin_in);
            d_dly_r[0] <= (ttl_sel || !hit_ok) ? 2'b00
                : ({diff_end_in_b, diff_end_in_a} & ~{pin_r[4], pin_r[3]});
            t_dly_r[0] <= (ttl_sel && hit_ok) ? (ttl_end_in & ~ttl_mask) : 8'h00;
            for (int i = 1; i < DLY; i++) begin
                b_dly_r[i] <= b_dly_r[i-1];
                d_dly_r[i] <= d_dly_r[i-1];
                t_dly_r[i] <= t_dly_r[i-1];
            end
        end
    end

    // Outputs gated by hit_ok; hits left in the delay line drop while it is low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            begin_hit <= 1'b0;
            diff_end_hit <= '0;
            ttl_end_hit <= '0;
            hits_open <= 1'b0;
        end else begin
            begin_hit <= b_dly_r[DLY-1] && hit_ok;
            diff_end_hit <= hit_ok ? d_dly_r[DLY-1] : 2'b00;
            ttl_end_hit <= hit_ok ? t_dly_r[DLY-1] : 8'h00;
            hits_open <= hit_ok;
        end
    end

    // ----------------------------------------------------------------
    // Host port strobes and core control
    // ----------------------------------------------------------------
    logic wr_d_r, rd_d_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_d_r <= 1'b0;
            rd_d_r <= 1'b0;
            wr_access <= 1'b0;
            rd_access <= 1'b0;
            core_init <= 1'b0;
        end else begin
            wr_d_r <= pin_r[7] && pin_r[8];
            rd_d_r <= pin_r[7] && pin_r[9];
            // One pulse per strobe, taken only under chip select
            wr_access <= pin_r[7] && pin_r[8] && !wr_d_r;
            rd_access <= pin_r[7] && pin_r[9] && !rd_d_r;
            core_init <= pin_pwrup;
        end
    end

    // Trim steps one count at a time toward target resolution
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_trim <= '0;
        end else if (res_adjust_en && !pin_pwrup) begin
            if (res_measured > res_target && core_trim != '1) begin
                core_trim <= core_trim + 1'b1;
            end else if (res_measured < res_target && core_trim != '0) begin
                core_trim <= core_trim - 1'b1;
            end
        end
    end

endmodule : tdcrg_dev
`default_nettype wire

// file: bench/tdcrg_checker.sv
// Pin checks between host controller and device end.
// Assumes instantiation beside the interface, all on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module tdcrg_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pwrup_reset,
    input wire logic master_reset,
    input wire logic partial_reset,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Width counters
    // ----------------------------------------------------------------
    logic [7:0] pw_r;
    logic [7:0] mr_r;
    logic [7:0] pr_r;

    // Counters, since 23 cycles is too long for a repetition
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pw_r <= 8'h00;
            mr_r <= 8'h00;
            pr_r <= 8'h00;
        end else begin
            pw_r <= pwrup_reset ? pw_r + 8'h01 : 8'h00;
            mr_r <= master_reset ? mr_r + 8'h01 : 8'h00;
            pr_r <= partial_reset ? pr_r + 8'h01 : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_pwrup_width: assert property ($fell(pwrup_reset)
        |-> pw_r == tdcrg_pkg::PWRUP_CYC + 3)
        else $error("power-up pulse width wrong");
    a_master_width: assert property ($fell(master_reset)
        |-> mr_r == tdcrg_pkg::PULSE_CYC + 3)
        else $error("master pulse width wrong");
    a_partial_width: assert property ($fell(partial_reset)
        |-> pr_r == tdcrg_pkg::PULSE_CYC + 3)
        else $error("partial pulse width wrong");
    a_write_needs_cs: assert property (!write_strobe_n |-> !chip_select_n)
        else $error("write strobe without select");
    a_read_needs_cs: assert property (!read_strobe_n |-> !chip_select_n)
        else $error("read strobe without select");
    a_strobes_apart: assert property (!(!write_strobe_n && !read_strobe_n))
        else $error("both strobes low");
    a_write_low_len: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4])
        else $error("write strobe too short");
    a_read_low_len: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*4])
        else $error("read strobe too short");

    c_master: cover property ($fell(master_reset));
    c_partial: cover property ($fell(partial_reset));
    c_write: cover property ($rose(write_strobe_n));
    c_read: cover property ($rose(read_strobe_n));
endmodule : tdcrg_checker
`default_nettype wire

// file: bench/tdc_reset_and_hit_gating_tb_top.sv
// Testbench: host controller and device end joined by the interface.
// Assumes ref_clk at 100 MHz; the bench drives commands and hit pulses.
`timescale 1ns/1ns
`default_nettype none
module tdc_reset_and_hit_gating_tb_top;
    logic ref_clk, rst, cmd_valid, cmd_ready, ttl_sel, res_adjust_en;
    tdcrg_pkg::tdcrg_cmd_t cmd;
    logic [4:0] mask_set;
    logic diff_begin_in, diff_end_in_a, diff_end_in_b, ttl_begin_in;
    logic [7:0] ttl_end_in, res_target, res_measured, ttl_end_hit, core_trim;
    logic begin_hit, hits_open, wr_access, rd_access, core_init;
    logic [1:0] diff_end_hit;
    int err_total, num_checks, low_cnt;

    tdcrg_if link_if ();
    tdcrg_host i_tdcrg_host (.ref_clk(ref_clk), .rst(rst), .link(link_if),
        .cmd_valid(cmd_valid), .cmd(cmd), .mask_set(mask_set), .cmd_ready(cmd_ready));
    tdcrg_dev #(.LOSS_CYC(2), .RES_W(8)) i_tdcrg_dev (.ref_clk(ref_clk), .rst(rst),
        .link(link_if), .ttl_sel(ttl_sel), .diff_begin_in(diff_begin_in),
        .diff_end_in_a(diff_end_in_a), .diff_end_in_b(diff_end_in_b),
        .ttl_begin_in(ttl_begin_in), .ttl_end_in(ttl_end_in), .res_adjust_en(res_adjust_en),
        .res_target(res_target), .res_measured(res_measured), .begin_hit(begin_hit),
        .diff_end_hit(diff_end_hit), .ttl_end_hit(ttl_end_hit), .hits_open(hits_open),
        .wr_access(wr_access), .rd_access(rd_access), .core_init(core_init),
        .core_trim(core_trim));
    tdcrg_checker i_tdcrg_checker (.ref_clk(ref_clk), .rst(rst),
        .pwrup_reset(link_if.pwrup_reset), .master_reset(link_if.master_reset),
        .partial_reset(link_if.partial_reset), .chip_select_n(link_if.chip_select_n),
        .write_strobe_n(link_if.write_strobe_n), .read_strobe_n(link_if.read_strobe_n));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Inputs move 1 ns after the edge, clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic send(input tdcrg_pkg::tdcrg_cmd_t c);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 60) begin
            tick(1);
            k++;
        end
        err_total += (k >= 60);
        cmd = c;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
    endtask : send

    // One-cycle hits on the pins set in pins; outputs gathered over 8 cycles
    task automatic fire(input logic [10:0] pins, output logic [10:0] seen);
        {ttl_end_in, diff_end_in_b, diff_end_in_a, diff_begin_in} = pins;
        ttl_begin_in = pins[0];
        seen = 11'h000;
        tick(1);
        {ttl_end_in, diff_end_in_b, diff_end_in_a, diff_begin_in} = 11'h000;
        ttl_begin_in = 1'b0;
        repeat (8) begin
            seen = seen | {ttl_end_hit, diff_end_hit, begin_hit};
            tick(1);
        end
    endtask : fire

    // Closed-gate cycles, counted beside the scenarios
    always @(posedge ref_clk) begin
        if (hits_open === 1'b0) low_cnt++;
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_pwrup;
        int k;
        k = 0;
        send(tdcrg_pkg::TDCRG_CMD_PWRUP);
        while (core_init !== 1'b1 && k < 10) begin
            tick(1);
            k++;
        end
        k = 0;
        while (core_init === 1'b1 && k < 60) begin
            tick(1);
            k++;
        end
        check(k >= tdcrg_pkg::PWRUP_CYC, 1'b1);
        $display("test pwrup done");
    endtask : t_pwrup

    // A hit just after the pin rises is dropped; one after reopening passes
    task automatic t_window(input tdcrg_pkg::tdcrg_cmd_t c, input int rise);
        logic [10:0] seen;
        int k, hold;
        k = 0;
        hold = tdcrg_pkg::PULSE_CYC + 3 + tdcrg_pkg::FALL_HOLD_CYC;
        ttl_sel = 1'b1;
        send(c);
        low_cnt = 0;
        while (!(link_if.master_reset === 1'b1 || link_if.partial_reset === 1'b1) && k < 10) begin
            tick(1);
            k++;
        end
        fire(11'h001, seen);
        check(seen[0], 1'b0);
        k = 0;
        while (hits_open !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        err_total += (k >= 40);
        check(low_cnt >= ((rise > hold) ? rise : hold), 1'b1);
        fire(11'h001, seen);
        check(seen[0], 1'b1);
        $display("test reset window done");
    endtask : t_window

    // A hit standing two cycles ahead of a partial rise is lost with it
    task automatic t_preloss;
        logic [7:0] seen;
        int k;
        k = 0;
        ttl_sel = 1'b1;
        ttl_begin_in = 1'b1;
        send(tdcrg_pkg::TDCRG_CMD_PARTIAL);
        ttl_begin_in = 1'b0;
        seen = 8'h00;
        repeat (8) begin
            seen = seen | {7'h00, begin_hit};
            tick(1);
        end
        check(seen, 8'h00);
        while (hits_open !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        err_total += (k >= 40);
        $display("test pre-reset loss done");
    endtask : t_preloss

    task automatic t_masks;
        logic [10:0] seen, exp;
        logic [4:0] m;
        for (int s = 0; s < 2; s++) begin
            ttl_sel = s[0];
            for (int i = 0; i < 6; i++) begin
                m = (i < 5) ? (5'h01 << i) : 5'h00;
                mask_set = m;
                tick(10);
                fire(11'h7ff, seen);
                exp = {{2{~m[4]}}, {2{~m[3]}}, {2{~m[2]}}, {2{~m[1]}}, ~m[2], ~m[1], ~m[0]};
                check(seen[0], exp[0]);
                if (s == 1) begin
                    check(seen[10:3], exp[10:3]);
                    check(seen[2:1], 2'b00);
                end else begin
                    check(seen[2:1], exp[2:1]);
                    check(seen[10:3], 8'h00);
                end
            end
        end
        mask_set = 5'h00;
        $display("test masks done");
    endtask : t_masks

    task automatic t_access(input tdcrg_pkg::tdcrg_cmd_t c, input int ew, input int er);
        int w, r;
        w = 0;
        r = 0;
        send(c);
        repeat (14) begin
            w += (wr_access === 1'b1);
            r += (rd_access === 1'b1);
            tick(1);
        end
        check(w[7:0], ew[7:0]);
        check(r[7:0], er[7:0]);
        $display("test access done");
    endtask : t_access

    // Trim steps toward target and saturates at zero
    task automatic t_trim;
        logic [7:0] t1;
        res_adjust_en = 1'b1;
        res_target = 8'h80;
        res_measured = 8'h90;
        tick(4);
        t1 = core_trim;
        tick(6);
        check(core_trim > t1, 1'b1);
        res_measured = 8'h70;
        t1 = core_trim;
        tick(6);
        check(core_trim < t1, 1'b1);
        tick(40);
        check(core_trim, 8'h00);
        $display("test trim done");
    endtask : t_trim

    task automatic end_sim;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Run needs some 420 cycles; 60 us leaves ample margin
    initial begin
        #60000;
        err_total++;
        end_sim;
    end

    initial begin
        rst = 1'b1;
        {cmd_valid, ttl_sel, res_adjust_en, mask_set} = 8'h00;
        cmd = tdcrg_pkg::TDCRG_CMD_WRITE;
        {ttl_end_in, diff_end_in_b, diff_end_in_a, diff_begin_in, ttl_begin_in} = 12'h000;
        {res_target, res_measured} = 16'h0000;
        err_total = 0;
        num_checks = 0;
        low_cnt = 0;
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        tick(3);
        t_pwrup();
        tick(10);
        t_window(tdcrg_pkg::TDCRG_CMD_MASTER, tdcrg_pkg::MASTER_RISE_CYC);
        t_window(tdcrg_pkg::TDCRG_CMD_PARTIAL, tdcrg_pkg::PARTIAL_RISE_CYC);
        t_preloss();
        t_masks();
        t_access(tdcrg_pkg::TDCRG_CMD_WRITE, 1, 0);
        t_access(tdcrg_pkg::TDCRG_CMD_READ, 0, 1);
        t_trim();
        end_sim;
    end
endmodule : tdc_reset_and_hit_gating_tb_top
`default_nettype wire
